// [cfpc_cfg.svh]
// Summary of operation
// - user array is 256 pages of 128 bytes
// - separate 128-byte extra row for boot data
// - security upper nibble software, lower parallel only
// - page buffer is the only software write path
// - launch only when executing from boot flash
// - boot flash never programmable by software
// - boot flash mapped at F800h-FFFFh when enabled
// - after reset user array is read-only code
// - page-buffer map routes data writes 0000h-7FFFh
// - address bits 6:0 byte, 14:7 page
// - page-buffer map overrides external RAM select
// - space select maps user, extra row, security
// - key 5 then key A launches programming
// - launch copies buffer to selected target only
// - unlock writes must be consecutive instructions
// - busy flag high during programming
// - busy cleared by hardware, not by software
// - latest buffer write selects programmed page
// - erase then program only loaded bytes
`ifndef CFPC_CFG_SVH
`define CFPC_CFG_SVH
`define CFPC_PAGE_BYTES 128
`define CFPC_PAGES      256
`define CFPC_KEY_MSB    7
`define CFPC_KEY_LSB    4
`define CFPC_MAP_BIT    3
`define CFPC_SEL_MSB    2
`define CFPC_SEL_LSB    1
`define CFPC_BUSY_BIT   0
`define CFPC_KEY_ARM    4'h5
`define CFPC_KEY_GO     4'hA
`define CFPC_USER_TOP   16'h7FFF
`define CFPC_EXTRA_ROW_BASE  16'hFF80
`define CFPC_BOOT_BASE  16'hF800
`define CFPC_SEC_ADDR   16'h0000
`define CFPC_SEC_RST    8'hFF
`define CFPC_LAST_IDX   7'h7F
`endif

// [cfpc_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
`include "cfpc_cfg.svh"
module cfpc_ctrl (
  // clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_resetn,
  // core instruction and control register port
  input  wire logic              i_instr_end,
  input  wire logic              i_exec_boot,
  input  wire logic              i_fcr_wr,
  input  wire logic [7:0]        i_fcr_wdata,
  output logic      [7:0]        o_flash_control_reg,
  output logic                   o_program_busy_flag,
  // auxiliary register bits
  input  wire logic              i_boot_map_enable,
  input  wire logic              i_ext_ram_select,
  // external data write path
  input  wire logic              i_xwr,
  input  wire logic [15:0]       i_xaddr,
  input  wire logic [7:0]        i_xwdata,
  output logic                   o_xwr_pbuf,
  output logic                   o_xwr_ram,
  output logic                   o_xram_ext,
  // code read decode
  input  wire logic [15:0]       i_caddr,
  output cfpc_pkg::cfpc_route_t  o_code_route,
  output logic      [7:0]        o_sec_byte,
  // flash array macro
  output logic                   o_fl_req,
  output logic                   o_fl_erase,
  output cfpc_pkg::cfpc_space_t  o_fl_target,
  output logic      [14:0]       o_fl_addr,
  output logic      [7:0]        o_fl_data,
  input  wire logic              i_fl_ack,
  // parallel programmer pins
  input  wire logic              i_pp_active,
  input  wire logic              i_pp_sec_wr,
  input  wire logic [3:0]        i_pp_sec_data,
  output logic                   o_boot_prog_en
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic f_in_user(input logic [15:0] a);
    f_in_user = (a <= `CFPC_USER_TOP);
  endfunction : f_in_user

  // key nibble compare, shared by both unlock writes
  function automatic logic f_key_is(input logic [7:0] d, input logic [3:0] k);
    f_key_is = (d[`CFPC_KEY_MSB:`CFPC_KEY_LSB] == k);
  endfunction : f_key_is

  // phase after the last slot: erase hands over to program, program to done
  function automatic cfpc_pkg::cfpc_state_t f_walk_end(input cfpc_pkg::cfpc_state_t st);
    f_walk_end = (st == cfpc_pkg::ST_ERASE) ? cfpc_pkg::ST_PROG : cfpc_pkg::ST_DONE;
  endfunction : f_walk_end

  cfpc_pkg::cfpc_regs_t s;
  cfpc_pkg::cfpc_regs_t next_s;
  logic                 key_arm;
  logic                 key_go;
  logic                 go;
  logic                 busy;
  cfpc_pkg::cfpc_space_t wsel;
  logic [6:0]           xbyte;
  logic [7:0]           xpage;
  logic                 pp_edge;
  logic [3:0]           pp_nib;
  logic [3:0]           sec_lo;

  // ----------------------------------------
  // control register decode
  // ----------------------------------------
  // launch only from boot code and idle; reserved target arms but never starts
  assign wsel    = cfpc_pkg::cfpc_space_t'(i_fcr_wdata[`CFPC_SEL_MSB:`CFPC_SEL_LSB]);
  assign key_arm = i_fcr_wr && f_key_is(i_fcr_wdata, `CFPC_KEY_ARM);
  assign key_go  = i_fcr_wr && f_key_is(i_fcr_wdata, `CFPC_KEY_GO);
  assign go      = key_go && s.armed && i_exec_boot && (s.state == cfpc_pkg::ST_IDLE)
                   && (wsel != cfpc_pkg::SP_RSVD);
  assign busy    = (s.state != cfpc_pkg::ST_IDLE);
  // synchronised pin edge and the nibble it loads
  assign pp_edge = s.pp_wr[1] && !s.pp_wr_d;
  assign pp_nib  = s.pp_dat1;
  assign sec_lo  = s.sec[3:0];

  // ----------------------------------------
  // data space routing
  // ----------------------------------------
  // the map bit wins over the external RAM select inside the buffer window
  assign o_xwr_pbuf = i_xwr && s.map && f_in_user(i_xaddr);
  assign o_xwr_ram  = i_xwr && !o_xwr_pbuf;
  assign o_xram_ext = i_ext_ram_select && !(s.map && f_in_user(i_xaddr));
  // byte slot and page fields of a buffer write
  assign xbyte      = i_xaddr[6:0];
  assign xpage      = i_xaddr[14:7];

  // ----------------------------------------
  // code space routing
  // ----------------------------------------
  // boot window checked first so an enabled boot flash shadows the extra row
  always_comb begin
    if (i_boot_map_enable && (i_caddr >= `CFPC_BOOT_BASE)) begin
      o_code_route = cfpc_pkg::RT_BOOT;
    end else if ((s.sel == cfpc_pkg::SP_EXTRA_ROW) && (i_caddr >= `CFPC_EXTRA_ROW_BASE)) begin
      o_code_route = cfpc_pkg::RT_EXTRA_ROW;
    end else if ((s.sel == cfpc_pkg::SP_SEC) && (i_caddr == `CFPC_SEC_ADDR)) begin
      o_code_route = cfpc_pkg::RT_SEC;
    end else if (f_in_user(i_caddr)) begin
      o_code_route = cfpc_pkg::RT_USER;
    end else begin
      o_code_route = cfpc_pkg::RT_EXT;
    end
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    next_s = s;
    // pin synchronisers, second stage is the only reader of the first
    next_s.pp_act  = {s.pp_act[0], i_pp_active};
    next_s.pp_wr   = {s.pp_wr[0], i_pp_sec_wr};
    next_s.pp_dat0 = i_pp_sec_data;
    next_s.pp_dat1 = s.pp_dat0;
    next_s.pp_wr_d = s.pp_wr[1];
    // lower security nibble only through the parallel programmer
    if (pp_edge) begin
      next_s.sec[3:0] = pp_nib;
    end
    // control writes keep map and select; busy is never software written
    if (i_fcr_wr) begin
      next_s.map   = i_fcr_wdata[`CFPC_MAP_BIT];
      next_s.sel   = wsel;
      next_s.armed = key_arm;
    end else if (i_instr_end) begin
      next_s.armed = 1'b0;
    end
    // buffer load, refused while programming runs
    if (o_xwr_pbuf && !busy) begin
      next_s.pbuf[xbyte]   = i_xwdata;
      next_s.loaded[xbyte] = 1'b1;
      next_s.page          = xpage;
    end
    unique case (s.state)
      cfpc_pkg::ST_IDLE: begin
        if (go) begin
          next_s.state  = cfpc_pkg::ST_ERASE;
          next_s.target = wsel;
          next_s.idx    = 7'h00;
        end
      end
      cfpc_pkg::ST_ERASE,
      cfpc_pkg::ST_PROG: begin
        // walk every byte slot; unloaded slots cost one cycle and are skipped
        if (s.fl_req) begin
          if (i_fl_ack) begin
            next_s.fl_req = 1'b0;
            if ((s.state == cfpc_pkg::ST_PROG) && (s.target == cfpc_pkg::SP_SEC)) begin
              next_s.sec[7:4] = s.pbuf[0][7:4];
            end
            next_s.idx = s.idx + 7'h01;
            if (s.idx == `CFPC_LAST_IDX) begin
              next_s.state = f_walk_end(s.state);
            end
          end
        end else if (s.loaded[s.idx] &&
                     ((s.target != cfpc_pkg::SP_SEC) || (s.idx == 7'h00))) begin
          next_s.fl_req   = 1'b1;
          next_s.fl_erase = (s.state == cfpc_pkg::ST_ERASE);
          next_s.fl_addr  = {s.page, s.idx};
          next_s.fl_data  = s.pbuf[s.idx];
        end else begin
          next_s.idx = s.idx + 7'h01;
          if (s.idx == `CFPC_LAST_IDX) begin
            next_s.state = f_walk_end(s.state);
          end
        end
      end
      cfpc_pkg::ST_DONE: begin
        next_s.loaded = '0;
        next_s.state  = cfpc_pkg::ST_IDLE;
      end
      default: begin
        next_s.state = cfpc_pkg::ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      s        <= '0;
      s.state  <= cfpc_pkg::ST_IDLE;
      s.target <= cfpc_pkg::SP_USER;
      s.sel    <= cfpc_pkg::SP_USER;
      s.sec    <= `CFPC_SEC_RST;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign o_program_busy_flag = busy;
  assign o_flash_control_reg = {4'h0, s.map, s.sel, busy};
  assign o_sec_byte          = s.sec;
  assign o_fl_req            = s.fl_req;
  assign o_fl_erase          = s.fl_erase;
  assign o_fl_target         = s.target;
  assign o_fl_addr           = s.fl_addr;
  assign o_fl_data           = s.fl_data;
  // boot flash writes belong to the parallel programmer alone
  assign o_boot_prog_en      = s.pp_act[1];

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  sequence s_arm_write;
    key_arm && i_instr_end;
  endsequence
  sequence s_go_write;
    go;
  endsequence

  property p_launch_busy;
    @(posedge i_clk) disable iff (!i_resetn)
    s_go_write |=> o_program_busy_flag[*2];
  endproperty
  a_launch_busy: assert property (p_launch_busy) else $error("launch did not raise busy");

  property p_user_launch_void;
    @(posedge i_clk) disable iff (!i_resetn)
    (!busy && i_fcr_wr && !i_exec_boot) |=> !o_program_busy_flag;
  endproperty
  a_user_launch_void: assert property (p_user_launch_void) else $error("launch from user code");

  property p_gap_aborts;
    @(posedge i_clk) disable iff (!i_resetn)
    s_arm_write ##1 (i_instr_end && !i_fcr_wr) ##1 (key_go && !busy) |=> !o_program_busy_flag;
  endproperty
  a_gap_aborts: assert property (p_gap_aborts) else $error("non-consecutive unlock launched");

  property p_pbuf_route;
    @(posedge i_clk) disable iff (!i_resetn)
    (i_xwr && s.map && f_in_user(i_xaddr)) |-> (o_xwr_pbuf && !o_xwr_ram && !o_xram_ext);
  endproperty
  a_pbuf_route: assert property (p_pbuf_route) else $error("buffer write leaked to data memory");

  property p_page_latest;
    @(posedge i_clk) disable iff (!i_resetn)
    (o_xwr_pbuf && !busy) |=> (s.page == $past(xpage) && s.loaded[$past(xbyte)]);
  endproperty
  a_page_latest: assert property (p_page_latest) else $error("page or loaded flag not taken");

  property p_extra_row_map;
    @(posedge i_clk) disable iff (!i_resetn)
    (s.sel == cfpc_pkg::SP_EXTRA_ROW && !i_boot_map_enable && i_caddr >= `CFPC_EXTRA_ROW_BASE)
      |-> (o_code_route == cfpc_pkg::RT_EXTRA_ROW);
  endproperty
  a_extra_row_map: assert property (p_extra_row_map) else $error("extra row not mapped");

  property p_busy_sw_proof;
    @(posedge i_clk) disable iff (!i_resetn)
    (s.state == cfpc_pkg::ST_ERASE && i_fcr_wr) |=> o_program_busy_flag;
  endproperty
  a_busy_sw_proof: assert property (p_busy_sw_proof) else $error("software changed busy");

  property p_flags_cleared;
    @(posedge i_clk) disable iff (!i_resetn)
    (s.state == cfpc_pkg::ST_DONE) |=> (s.loaded == '0 && !o_program_busy_flag);
  endproperty
  a_flags_cleared: assert property (p_flags_cleared) else $error("loaded flags survive");

  property p_only_loaded;
    @(posedge i_clk) disable iff (!i_resetn)
    $rose(o_fl_req) |-> s.loaded[o_fl_addr[6:0]] && o_fl_erase == (s.state == cfpc_pkg::ST_ERASE);
  endproperty
  a_only_loaded: assert property (p_only_loaded) else $error("unloaded byte touched");

  // flash handshake: request waits, then completes on ack
  sequence s_req_wait;
    o_fl_req && !i_fl_ack;
  endsequence
  sequence s_req_done;
    o_fl_req && i_fl_ack;
  endsequence

  property p_req_holds;
    @(posedge i_clk) disable iff (!i_resetn)
    s_req_wait |=> (o_fl_req && $stable(o_fl_addr) && $stable(o_fl_data) && $stable(o_fl_erase));
  endproperty
  a_req_holds: assert property (p_req_holds) else $error("flash request moved before ack");

  property p_req_drop;
    @(posedge i_clk) disable iff (!i_resetn)
    s_req_done |=> !o_fl_req;
  endproperty
  a_req_drop: assert property (p_req_drop) else $error("flash request held after ack");

  property p_fl_addr_map;
    @(posedge i_clk) disable iff (!i_resetn)
    $rose(o_fl_req) |-> (o_fl_addr == {s.page, s.idx});
  endproperty
  a_fl_addr_map: assert property (p_fl_addr_map) else $error("flash address not page and slot");

  property p_sec_lower_hold;
    @(posedge i_clk) disable iff (!i_resetn)
    !pp_edge |=> $stable(sec_lo);
  endproperty
  a_sec_lower_hold: assert property (p_sec_lower_hold) else $error("lower security nibble moved");

  property p_sec_pp_load;
    @(posedge i_clk) disable iff (!i_resetn)
    pp_edge |=> (sec_lo == $past(pp_nib));
  endproperty
  a_sec_pp_load: assert property (p_sec_pp_load) else $error("parallel nibble not loaded");

  property p_target_legal;
    @(posedge i_clk) disable iff (!i_resetn)
    o_fl_req |-> (o_fl_target != cfpc_pkg::SP_RSVD);
  endproperty
  a_target_legal: assert property (p_target_legal) else $error("request to reserved target");

  property p_sec_route;
    @(posedge i_clk) disable iff (!i_resetn)
    (s.sel == cfpc_pkg::SP_SEC && !i_boot_map_enable && i_caddr == `CFPC_SEC_ADDR) |-> (o_code_route == cfpc_pkg::RT_SEC);
  endproperty
  a_sec_route: assert property (p_sec_route) else $error("security byte not mapped");

  property p_rsvd_void;
    @(posedge i_clk) disable iff (!i_resetn)
    (key_go && s.armed && !busy && wsel == cfpc_pkg::SP_RSVD) |=> !o_program_busy_flag;
  endproperty
  a_rsvd_void: assert property (p_rsvd_void) else $error("reserved select launched");

  property p_disarm;
    @(posedge i_clk) disable iff (!i_resetn)
    (i_fcr_wr && !key_arm) |=> !s.armed;
  endproperty
  a_disarm: assert property (p_disarm) else $error("unlock stayed armed");

  property p_idle_quiet;
    @(posedge i_clk) disable iff (!i_resetn)
    (s.state == cfpc_pkg::ST_IDLE) |-> !o_fl_req;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("flash request while idle");

  property p_buf_store;
    @(posedge i_clk) disable iff (!i_resetn)
    (o_xwr_pbuf && !busy) |=> (s.pbuf[$past(xbyte)] == $past(i_xwdata));
  endproperty
  a_buf_store: assert property (p_buf_store) else $error("buffer byte not stored");

endmodule : cfpc_ctrl
`default_nettype wire

// [cfpc_flash_model.sv]
`timescale 1ns/1ps
`default_nettype none
module cfpc_flash_model (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  // request side of the array macro
  input  wire logic        i_req,
  input  wire logic        i_erase,
  input  wire logic [14:0] i_addr,
  input  wire logic [7:0]  i_data,
  input  wire logic [3:0]  i_delay,
  output logic             o_ack,
  // what the array has seen
  output var int           o_n_erase,
  output var int           o_n_prog,
  output logic [14:0]      o_last_addr,
  output logic [7:0]       o_last_data
);
  int cnt;
  // one ack pulse after a chosen wait; cells are slow, so the wait is the stall
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_ack       <= 1'b0;
      cnt         <= 0;
      o_n_erase   <= 0;
      o_n_prog    <= 0;
      o_last_addr <= 15'h0000;
      o_last_data <= 8'h00;
    end else if (o_ack) begin
      // request is still held here, so record it as it completes
      o_ack <= 1'b0;
      cnt   <= 0;
      if (i_erase) begin
        o_n_erase <= o_n_erase + 1;
      end else begin
        o_n_prog    <= o_n_prog + 1;
        o_last_addr <= i_addr;
        o_last_data <= i_data;
      end
    end else if (i_req) begin
      if (cnt >= int'(i_delay)) begin
        o_ack <= 1'b1;
      end
      cnt <= cnt + 1;
    end
  end
endmodule : cfpc_flash_model
`default_nettype wire

// [cfpc_pkg.sv]
`include "cfpc_cfg.svh"
package cfpc_pkg;
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_ERASE = 4'b0010,
    ST_PROG  = 4'b0100,
    ST_DONE  = 4'b1000
  } cfpc_state_t;
  typedef enum logic [1:0] {
    SP_USER = 2'b00,
    SP_EXTRA_ROW = 2'b01,
    SP_SEC  = 2'b10,
    SP_RSVD = 2'b11
  } cfpc_space_t;
  typedef enum logic [2:0] {
    RT_USER = 3'h0,
    RT_EXTRA_ROW = 3'h1,
    RT_SEC  = 3'h2,
    RT_BOOT = 3'h3,
    RT_EXT  = 3'h4
  } cfpc_route_t;
  typedef struct packed {
    logic [1:0]                           pp_act;
    logic [1:0]                           pp_wr;
    logic [3:0]                           pp_dat0;
    logic [3:0]                           pp_dat1;
    logic                                 pp_wr_d;
    logic                                 map;
    cfpc_space_t                          sel;
    logic                                 armed;
    cfpc_state_t                          state;
    cfpc_space_t                          target;
    logic [6:0]                           idx;
    logic [7:0]                           page;
    logic                                 fl_req;
    logic                                 fl_erase;
    logic [14:0]                          fl_addr;
    logic [7:0]                           fl_data;
    logic [7:0]                           sec;
    logic [`CFPC_PAGE_BYTES-1:0]          loaded;
    logic [`CFPC_PAGE_BYTES-1:0][7:0]     pbuf;
  } cfpc_regs_t;
endpackage : cfpc_pkg

// [test_code_flash_program_control.sv]
`timescale 1ns/1ps
`default_nettype none
module test_code_flash_program_control;
  logic clk, resetn, instr_end, exec_boot, fcr_wr, boot_map, ext_ram, xwr, fl_ack;
  logic pp_active, pp_sec_wr, busy, pbuf, ram, xext, fl_req, fl_erase, boot_en;
  logic [7:0] fcr_wdata, xwdata, fcr, sec, fl_data, last_data;
  logic [15:0] xaddr, caddr;
  logic [14:0] fl_addr, last_addr;
  logic [3:0] pp_sec_data, delay;
  cfpc_pkg::cfpc_route_t route;
  cfpc_pkg::cfpc_space_t fl_target;
  int n_erase, n_prog, err_total, n_tests;
  // ----------------------------------------
  // clock, design and array model
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  cfpc_ctrl u_cfpc_ctrl (.i_clk(clk), .i_resetn(resetn), .i_instr_end(instr_end), .i_exec_boot(exec_boot),
    .i_fcr_wr(fcr_wr), .i_fcr_wdata(fcr_wdata), .o_flash_control_reg(fcr), .o_program_busy_flag(busy),
    .i_boot_map_enable(boot_map), .i_ext_ram_select(ext_ram), .i_xwr(xwr), .i_xaddr(xaddr),
    .i_xwdata(xwdata), .o_xwr_pbuf(pbuf), .o_xwr_ram(ram), .o_xram_ext(xext), .i_caddr(caddr),
    .o_code_route(route), .o_sec_byte(sec), .o_fl_req(fl_req), .o_fl_erase(fl_erase),
    .o_fl_target(fl_target), .o_fl_addr(fl_addr), .o_fl_data(fl_data), .i_fl_ack(fl_ack),
    .i_pp_active(pp_active), .i_pp_sec_wr(pp_sec_wr), .i_pp_sec_data(pp_sec_data), .o_boot_prog_en(boot_en));
  cfpc_flash_model u_cfpc_flash_model (.i_clk(clk), .i_resetn(resetn), .i_req(fl_req), .i_erase(fl_erase),
    .i_addr(fl_addr), .i_data(fl_data), .i_delay(delay), .o_ack(fl_ack), .o_n_erase(n_erase),
    .o_n_prog(n_prog), .o_last_addr(last_addr), .o_last_data(last_data));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // control write ends its own instruction, as the core does
  task automatic cw(input logic [7:0] d);
    @(posedge clk);
    fcr_wr    <= 1'b1;
    instr_end <= 1'b1;
    fcr_wdata <= d;
    @(posedge clk);
    fcr_wr    <= 1'b0;
    instr_end <= 1'b0;
  endtask : cw
  task automatic ins();
    @(posedge clk);
    instr_end <= 1'b1;
    @(posedge clk);
    instr_end <= 1'b0;
  endtask : ins
  task automatic xw(input logic [15:0] a, input logic [7:0] d, input logic exp_pbuf);
    @(posedge clk);
    xwr    <= 1'b1;
    xaddr  <= a;
    xwdata <= d;
    #1;
    chk(16'(pbuf), 16'(exp_pbuf));
    chk(16'(ram), 16'(!exp_pbuf));
    chk(16'(xext), 16'(!exp_pbuf));
    @(posedge clk);
    xwr <= 1'b0;
  endtask : xw
  task automatic rt(input logic [15:0] a, input cfpc_pkg::cfpc_route_t exp);
    @(posedge clk);
    caddr <= a;
    #1;
    chk(16'(route), 16'(exp));
  endtask : rt
  task automatic busy_is(input logic exp);
    repeat (2) @(posedge clk);
    #1;
    chk(16'(busy), 16'(exp));
  endtask : busy_is
  // bounded wait: a stuck busy shows as a mismatch, not a hang
  task automatic wait_idle();
    for (int i = 0; i < 3000 && busy !== 1'b0; i++) begin
      @(posedge clk);
      #1;
    end
    chk(16'(busy), 16'h0000);
  endtask : wait_idle
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    #1;
    chk(16'(fcr), 16'h0000);
    chk(16'(sec), 16'h00FF);
    chk(16'(fl_req), 16'h0000);
    rt(16'h1234, cfpc_pkg::RT_USER);
    $display("test reset done");
  endtask : t_reset
  task automatic t_map();
    @(posedge clk);
    ext_ram <= 1'b1;
    cw(8'h08);
    #1;
    chk(16'(fcr), 16'h0008);
    xw(16'h7FFF, 8'h11, 1'b1);
    xw(16'h8000, 8'h22, 1'b0);
    cw(8'h0A);
    rt(16'hFF80, cfpc_pkg::RT_EXTRA_ROW);
    cw(8'h0C);
    rt(16'h0000, cfpc_pkg::RT_SEC);
    cw(8'h08);
    boot_map <= 1'b1;
    rt(16'hF800, cfpc_pkg::RT_BOOT);
    @(posedge clk);
    boot_map <= 1'b0;
    rt(16'hF800, cfpc_pkg::RT_EXT);
    $display("test map done");
  endtask : t_map
  task automatic t_prog();
    int e0;
    int p0;
    e0 = n_erase;
    p0 = n_prog;
    @(posedge clk);
    delay <= 4'd5;
    xw(16'h0105, 8'h33, 1'b1);
    xw(16'h0389, 8'h44, 1'b1);
    // a control write lands mid-run: busy stays set, only map and select change
    cw(8'h50);
    cw(8'hA0);
    busy_is(1'b1);
    chk(16'(fl_target), 16'(cfpc_pkg::SP_USER));
    cw(8'h08);
    busy_is(1'b1);
    chk(16'(fcr), 16'h0009);
    wait_idle();
    chk(16'(n_erase - e0), 16'h0003);
    chk(16'(n_prog - p0), 16'h0003);
    chk(16'(last_addr), 16'h03FF);
    chk(16'(last_data), 16'h0011);
    cw(8'h50);
    cw(8'hA0);
    busy_is(1'b1);
    wait_idle();
    chk(16'(n_prog - p0), 16'h0003);
    // extra row target: one byte at slot 12h of page 0
    cw(8'h08);
    xw(16'h0012, 8'h5A, 1'b1);
    cw(8'h52);
    cw(8'hA2);
    busy_is(1'b1);
    chk(16'(fl_target), 16'(cfpc_pkg::SP_EXTRA_ROW));
    wait_idle();
    chk(16'(n_prog - p0), 16'h0004);
    chk(16'(last_addr), 16'h0012);
    chk(16'(last_data), 16'h005A);
    $display("test program done");
  endtask : t_prog
  task automatic t_refuse();
    @(posedge clk);
    exec_boot <= 1'b0;
    cw(8'h50);
    cw(8'hA0);
    busy_is(1'b0);
    @(posedge clk);
    exec_boot <= 1'b1;
    cw(8'h50);
    ins();
    cw(8'hA0);
    busy_is(1'b0);
    // key 5, one plain instruction, key A in three back-to-back cycles
    @(posedge clk);
    fcr_wr    <= 1'b1;
    instr_end <= 1'b1;
    fcr_wdata <= 8'h50;
    @(posedge clk);
    fcr_wr    <= 1'b0;
    @(posedge clk);
    fcr_wr    <= 1'b1;
    fcr_wdata <= 8'hA0;
    @(posedge clk);
    fcr_wr    <= 1'b0;
    instr_end <= 1'b0;
    busy_is(1'b0);
    cw(8'h50);
    cw(8'h08);
    cw(8'hA0);
    busy_is(1'b0);
    cw(8'h56);
    cw(8'hA6);
    busy_is(1'b0);
    cw(8'h50);
    busy_is(1'b0);
    $display("test refuse done");
  endtask : t_refuse
  task automatic t_sec();
    cw(8'h0C);
    xw(16'h0000, 8'h3C, 1'b1);
    cw(8'h54);
    cw(8'hA4);
    busy_is(1'b1);
    chk(16'(fl_target), 16'(cfpc_pkg::SP_SEC));
    wait_idle();
    chk(16'(sec), 16'h003F);
    @(posedge clk);
    pp_active   <= 1'b1;
    pp_sec_data <= 4'h5;
    repeat (3) @(posedge clk);
    pp_sec_wr <= 1'b1;
    repeat (3) @(posedge clk);
    pp_sec_wr <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
    chk(16'(sec), 16'h0035);
    chk(16'(boot_en), 16'h0001);
    $display("test security done");
  endtask : t_sec
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : summarize
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    {resetn, instr_end, fcr_wr, boot_map, ext_ram, xwr, pp_active, pp_sec_wr} = '0;
    {fcr_wdata, xwdata, xaddr, caddr, pp_sec_data} = '0;
    exec_boot = 1'b1;
    delay     = 4'd1;
    err_total = 0;
    n_tests   = 0;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    t_reset();
    t_map();
    t_prog();
    t_refuse();
    t_sec();
    summarize();
  end
  initial begin
    repeat (40000) @(posedge clk);
    err_total++;
    summarize();
  end
endmodule : test_code_flash_program_control
`default_nettype wire
